// ==== core/xmbi_defs.svh ====
// Constants for the external memory bus interface: timing, reset values and address map.
`ifndef XMBI_DEFS_SVH
`define XMBI_DEFS_SVH

// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define XMBI_ADDR_W        20
`define XMBI_LOW_ADDR_W    16
`define XMBI_DATA_W        16
`define XMBI_WAIT_W        3

// ----------------------------------------------------------------------------
// Reset and mapping values
// ----------------------------------------------------------------------------
`define XMBI_RESET_PC      16'hFF80
`define XMBI_ROM_BASE      16'hF000
`define XMBI_HIGH_ZERO     4'h0
`define XMBI_READY_MIN_WS  3'h2
`define XMBI_WS_ONE        3'h1
`define XMBI_WS_ZERO       3'h0

`endif

// ==== core/xmbi_pkg.sv ====
// Types shared by the external memory bus interface files.
package xmbi_pkg;
    typedef enum logic [1:0] {
        XMBI_SPACE_PROG,
        XMBI_SPACE_DATA,
        XMBI_SPACE_IO
    } xmbi_space_t;
endpackage

// ==== core/xmbi_sync.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pin inputs.
`timescale 1ns/1ps
module xmbi_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_next;

    // The first stage feeds only the second stage, to contain metastability.
    assign level_next = (s2_reg == s3_reg) ? s3_reg : level_out;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg    <= 1'b1;
            s2_reg    <= 1'b1;
            s3_reg    <= 1'b1;
            level_out <= 1'b1;
        end else begin
            s1_reg    <= pin_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_out <= level_next;
        end
    end
endmodule // xmbi_sync

// ==== core/xmbi_addr_map.sv ====
// Address mapping: on-chip ROM window and upper address-line enable.
`timescale 1ns/1ps
`include "xmbi_defs.svh"
module xmbi_addr_map (
    input  wire logic                      rom_enabled,
    input  wire xmbi_pkg::xmbi_space_t     space,
    input  wire logic [`XMBI_ADDR_W-1:0]   addr,
    output logic                           is_internal,
    output logic [`XMBI_ADDR_W-1:0]        addr_out
);
    import xmbi_pkg::*;

    logic in_rom_window;

    // The top 4K words of each 64K program page belong to on-chip ROM.
    assign in_rom_window = (addr[`XMBI_LOW_ADDR_W-1:0] >= `XMBI_ROM_BASE);
    assign is_internal   = rom_enabled && (space == XMBI_SPACE_PROG) && in_rom_window;
    // Upper lines carry address only for program space.
    assign addr_out = (space == XMBI_SPACE_PROG) ? addr
                    : {`XMBI_HIGH_ZERO, addr[`XMBI_LOW_ADDR_W-1:0]};
endmodule // xmbi_addr_map

// ==== core/xmbi_bus.sv ====
// External memory and I/O bus interface of the processor: strobes, wait states, hold and reset fetch.
`timescale 1ns/1ps
`include "xmbi_defs.svh"

// What this block does
// - Space selects idle high; only the addressed external space select goes low.
// - A space select is low only while the address bus is valid.
// - Memory strobe idles high, low only for external program or data access.
// - I/O strobe idles high, low only for external I/O access.
// - Direction output is high for read, low only during external writes.
// - READY low stretches the access one cycle at a time until high.
// - READY is only looked at with two or more wait states programmed.
// - READY is not sampled until all programmed wait states have elapsed.
// - A hold request, once acknowledged, floats address, data and control lines.
// - Hold acknowledge asserts while the bus is floated in the hold state.
// - Hold acknowledge is driven high, inactive, throughout reset.
// - Selects, strobes and direction float while in hold.
// - Wait-complete goes low at first wait state, high at the last one, when two or more are set.
// - Fetch indicator is low while the address is an instruction fetch.
// - Output-disable low floats fetch, wait-complete, strobes, selects, direction, grant.
// - After reset release the first program fetch is at address FF80.
// - Mode pin low at reset maps on-chip ROM into the top 4K words of each 64K program page.
// - Mode pin is sampled only at reset; a software mode bit may override.
// - Low sixteen address lines for all spaces; upper four only for program.
// - Data bus floats unless writing, and during reset or hold request.
module xmbi_bus (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        chip_reset_n,
    input  wire logic                        rom_map_select,
    input  wire logic                        mode_override_valid,
    input  wire logic                        mode_override_value,
    input  wire logic                        output_disable_n,
    input  wire logic                        ready,
    input  wire logic                        hold_req_n,
    input  wire logic [`XMBI_WAIT_W-1:0]     prog_wait_states,
    input  wire logic [`XMBI_WAIT_W-1:0]     data_wait_states,
    input  wire logic [`XMBI_WAIT_W-1:0]     io_wait_states,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire xmbi_pkg::xmbi_space_t       req_space,
    input  wire logic                        req_write,
    input  wire logic                        req_fetch,
    input  wire logic [`XMBI_ADDR_W-1:0]     req_addr,
    input  wire logic [`XMBI_DATA_W-1:0]     req_wdata,
    output logic                             rsp_valid,
    output logic [`XMBI_DATA_W-1:0]          rsp_rdata,
    output logic                             rsp_internal,
    output logic [`XMBI_ADDR_W-1:0]          reset_fetch_addr,
    output logic                             rom_mapped,
    output logic [`XMBI_ADDR_W-1:0]          addr_o,
    output logic                             addr_oe,
    output logic [`XMBI_DATA_W-1:0]          data_o,
    output logic                             data_oe,
    input  wire logic [`XMBI_DATA_W-1:0]     data_i,
    output logic                             data_space_sel_n,
    output logic                             program_space_sel_n,
    output logic                             io_space_sel_n,
    output logic                             memory_strobe_n,
    output logic                             io_strobe_n,
    output logic                             read_not_write,
    output logic                             ctrl_oe,
    output logic                             bus_grant_n,
    output logic                             wait_done_n,
    output logic                             fetch_cycle_n,
    output logic                             status_oe
);
    import xmbi_pkg::*;

    // ------------------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------------------
    logic rst_a_reg;
    logic rst_reg;
    wire  rst_n = rst_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_a_reg <= 1'b0;
            rst_reg   <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_reg   <= rst_a_reg;
        end
    end

    logic ready_s;
    logic hold_req_s_n;
    logic chip_reset_s_n;
    logic oe_s_n;
    logic map_pin_s;

    xmbi_sync u_sync_ready (.clk(clk), .rst_n(rst_n), .pin_in(ready), .level_out(ready_s));
    xmbi_sync u_sync_hold  (.clk(clk), .rst_n(rst_n), .pin_in(hold_req_n),
                            .level_out(hold_req_s_n));
    xmbi_sync u_sync_crst  (.clk(clk), .rst_n(rst_n), .pin_in(chip_reset_n),
                            .level_out(chip_reset_s_n));
    xmbi_sync u_sync_off   (.clk(clk), .rst_n(rst_n), .pin_in(output_disable_n),
                            .level_out(oe_s_n));
    xmbi_sync u_sync_map   (.clk(clk), .rst_n(rst_n), .pin_in(rom_map_select),
                            .level_out(map_pin_s));

    // ------------------------------------------------------------------------
    // Mode latch and reset fetch address
    // ------------------------------------------------------------------------
    logic mp_mode_reg;
    logic mp_mode_next;
    logic in_chip_reset;

    assign in_chip_reset = !chip_reset_s_n;
    // The pin is caught only while chip reset is low; software may override later.
    assign mp_mode_next = in_chip_reset       ? map_pin_s
                        : mode_override_valid ? mode_override_value
                        : mp_mode_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mp_mode_reg <= 1'b1;
        end else begin
            mp_mode_reg <= mp_mode_next;
        end
    end

    assign rom_mapped       = !mp_mode_reg;
    assign reset_fetch_addr = {`XMBI_HIGH_ZERO, `XMBI_RESET_PC};

    // ------------------------------------------------------------------------
    // Access state machine
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        XMBI_ST_IDLE,
        XMBI_ST_WAIT,
        XMBI_ST_READY,
        XMBI_ST_DONE,
        XMBI_ST_HOLD
    } xmbi_state_t;

    xmbi_state_t state_reg;
    xmbi_state_t state_next;
    xmbi_space_t space_reg;
    logic        write_reg;
    logic        fetch_reg;
    logic [`XMBI_ADDR_W-1:0]  addr_reg;
    logic [`XMBI_DATA_W-1:0]  wdata_reg;
    logic [`XMBI_DATA_W-1:0]  rdata_reg;
    logic [`XMBI_WAIT_W-1:0]  ws_total_reg;
    logic [`XMBI_WAIT_W-1:0]  ws_left_reg;
    logic [`XMBI_WAIT_W-1:0]  ws_left_next;
    logic                     rsp_valid_reg;
    logic                     rsp_int_reg;
    logic                     wait_done_reg;
    logic                     wait_done_next;

    function automatic logic [`XMBI_WAIT_W-1:0] pick_ws(input xmbi_space_t sp,
                                                      input logic [`XMBI_WAIT_W-1:0] p,
                                                      input logic [`XMBI_WAIT_W-1:0] d,
                                                      input logic [`XMBI_WAIT_W-1:0] i);
        case (sp)
            XMBI_SPACE_PROG: pick_ws = p;
            XMBI_SPACE_DATA: pick_ws = d;
            default:         pick_ws = i;
        endcase
    endfunction

    logic                    req_internal;
    logic [`XMBI_ADDR_W-1:0] mapped_addr;
    logic [`XMBI_WAIT_W-1:0] req_ws;
    logic                    take;
    logic                    hold_wanted;
    logic                    use_ready;
    logic                    ext_active;

    xmbi_addr_map u_map (
        .rom_enabled (rom_mapped),
        .space       (req_space),
        .addr        (req_addr),
        .is_internal (req_internal),
        .addr_out    (mapped_addr)
    );

    assign hold_wanted = !hold_req_s_n;
    assign req_ws      = pick_ws(req_space, prog_wait_states, data_wait_states, io_wait_states);
    assign req_ready   = (state_reg == XMBI_ST_IDLE) && !hold_wanted && !in_chip_reset;
    assign take        = req_valid && req_ready;
    assign use_ready   = (ws_total_reg >= `XMBI_READY_MIN_WS);
    assign ext_active  = (state_reg == XMBI_ST_WAIT) || (state_reg == XMBI_ST_READY) ||
                         (state_reg == XMBI_ST_DONE);

    always_comb begin
        state_next     = state_reg;
        ws_left_next   = ws_left_reg;
        wait_done_next = 1'b1;
        case (state_reg)
            XMBI_ST_IDLE: begin
                if (hold_wanted && !in_chip_reset) begin
                    state_next = XMBI_ST_HOLD;
                end else if (take && !req_internal) begin
                    ws_left_next = req_ws;
                    state_next   = (req_ws == `XMBI_WS_ZERO) ? XMBI_ST_DONE : XMBI_ST_WAIT;
                    // Goes low at the first wait state when two or more are set.
                    wait_done_next = !(req_ws >= `XMBI_READY_MIN_WS);
                end
            end
            XMBI_ST_WAIT: begin
                ws_left_next = ws_left_reg - `XMBI_WS_ONE;
                // Returns high as the last wait state begins.
                wait_done_next = !(use_ready && (ws_left_reg > `XMBI_READY_MIN_WS));
                if (ws_left_reg == `XMBI_WS_ONE) begin
                    state_next = use_ready ? XMBI_ST_READY : XMBI_ST_DONE;
                end
            end
            XMBI_ST_READY: begin
                // Each low sample costs one more cycle before looking again.
                if (ready_s) begin
                    state_next = XMBI_ST_DONE;
                end
            end
            XMBI_ST_DONE: begin
                state_next = XMBI_ST_IDLE;
            end
            XMBI_ST_HOLD: begin
                if (!hold_wanted) begin
                    state_next = XMBI_ST_IDLE;
                end
            end
            default: begin
                state_next = XMBI_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= XMBI_ST_IDLE;
            ws_left_reg   <= `XMBI_WS_ZERO;
            wait_done_reg <= 1'b1;
        end else begin
            state_reg     <= in_chip_reset ? XMBI_ST_IDLE : state_next;
            ws_left_reg   <= ws_left_next;
            wait_done_reg <= in_chip_reset ? 1'b1 : wait_done_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            space_reg    <= XMBI_SPACE_PROG;
            write_reg    <= 1'b0;
            fetch_reg    <= 1'b0;
            addr_reg     <= '0;
            wdata_reg    <= '0;
            ws_total_reg <= `XMBI_WS_ZERO;
        end else if (take) begin
            space_reg    <= req_space;
            write_reg    <= req_write;
            fetch_reg    <= req_fetch;
            addr_reg     <= mapped_addr;
            wdata_reg    <= req_wdata;
            ws_total_reg <= req_ws;
        end
    end

    // Internal ROM hits and external completions both answer the next cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_int_reg   <= 1'b0;
            rdata_reg     <= '0;
        end else begin
            rsp_valid_reg <= (take && req_internal) || (state_reg == XMBI_ST_DONE);
            rsp_int_reg   <= take && req_internal;
            if (state_reg == XMBI_ST_DONE && !write_reg) begin
                rdata_reg <= data_i;
            end
        end
    end

    assign rsp_valid    = rsp_valid_reg;
    assign rsp_internal = rsp_int_reg;
    assign rsp_rdata    = rdata_reg;

    // ------------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------------
    logic in_hold;
    logic pins_on;

    assign in_hold = (state_reg == XMBI_ST_HOLD);
    assign pins_on = oe_s_n && !in_hold;

    // Selects and strobes are decoded from the held access, so they fall only while the address is valid.
    assign data_space_sel_n    = !(ext_active && space_reg == XMBI_SPACE_DATA);
    assign program_space_sel_n = !(ext_active && space_reg == XMBI_SPACE_PROG);
    assign io_space_sel_n      = !(ext_active && space_reg == XMBI_SPACE_IO);
    assign memory_strobe_n     = !(ext_active && space_reg != XMBI_SPACE_IO);
    assign io_strobe_n         = !(ext_active && space_reg == XMBI_SPACE_IO);
    assign read_not_write      = !(ext_active && write_reg);
    assign fetch_cycle_n       = !(ext_active && fetch_reg);
    assign wait_done_n         = wait_done_reg;
    assign bus_grant_n         = !in_hold || in_chip_reset;

    assign ctrl_oe   = pins_on;
    assign status_oe = oe_s_n;
    assign addr_o    = addr_reg;
    assign addr_oe   = pins_on;
    assign data_o    = wdata_reg;
    // Write data is driven only during the write, never in reset or with hold pending.
    assign data_oe   = pins_on && ext_active && write_reg && !in_chip_reset && !hold_wanted;
endmodule // xmbi_bus

// ==== sim/xmbi_bus_props.sv ====
// Pin-level assertions for the external memory bus interface.
`timescale 1ns/1ps
`include "xmbi_defs.svh"
module xmbi_bus_props (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic                    chip_reset_n,
    input wire logic                    output_disable_n,
    input wire logic [`XMBI_ADDR_W-1:0] addr_o,
    input wire logic                    addr_oe,
    input wire logic                    data_oe,
    input wire logic                    data_space_sel_n,
    input wire logic                    program_space_sel_n,
    input wire logic                    io_space_sel_n,
    input wire logic                    memory_strobe_n,
    input wire logic                    io_strobe_n,
    input wire logic                    read_not_write,
    input wire logic                    ctrl_oe,
    input wire logic                    status_oe,
    input wire logic                    bus_grant_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_one_sel;
        $countones({data_space_sel_n, program_space_sel_n, io_space_sel_n}) >= 2;
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("two space selects low");
    property p_sel_addr;
        (!data_space_sel_n || !program_space_sel_n || !io_space_sel_n) |-> addr_oe;
    endproperty
    a_sel_addr: assert property (p_sel_addr) else $error("select low without address");
    property p_mem_strobe;
        !memory_strobe_n |-> (!data_space_sel_n || !program_space_sel_n) && io_space_sel_n;
    endproperty
    a_mem_strobe: assert property (p_mem_strobe) else $error("memory strobe outside memory access");
    property p_io_strobe;
        !io_strobe_n |-> !io_space_sel_n && memory_strobe_n;
    endproperty
    a_io_strobe: assert property (p_io_strobe) else $error("io strobe outside io access");
    property p_write_dir;
        !read_not_write |-> !memory_strobe_n || !io_strobe_n;
    endproperty
    a_write_dir: assert property (p_write_dir) else $error("write direction without access");
    property p_data_drive;
        data_oe |-> !read_not_write && bus_grant_n;
    endproperty
    a_data_drive: assert property (p_data_drive) else $error("data driven outside a write");
    property p_grant_float;
        !bus_grant_n |-> !ctrl_oe && !addr_oe && !data_oe;
    endproperty
    a_grant_float: assert property (p_grant_float) else $error("lines driven in hold");
    property p_grant_reset;
        !chip_reset_n [*5] |-> bus_grant_n;
    endproperty
    a_grant_reset: assert property (p_grant_reset) else $error("grant low during reset");
    property p_off;
        !output_disable_n [*6] |-> !ctrl_oe && !status_oe && !addr_oe;
    endproperty
    a_off: assert property (p_off) else $error("outputs driven while disabled");
    property p_upper;
        (!data_space_sel_n || !io_space_sel_n) |-> addr_o[19:16] == `XMBI_HIGH_ZERO;
    endproperty
    a_upper: assert property (p_upper) else $error("upper address lines on non-program access");
endmodule // xmbi_bus_props

bind xmbi_bus xmbi_bus_props u_xmbi_bus_props (.clk(clk), .reset_n(reset_n), .chip_reset_n(chip_reset_n),
    .output_disable_n(output_disable_n), .addr_o(addr_o), .addr_oe(addr_oe), .data_oe(data_oe),
    .data_space_sel_n(data_space_sel_n), .program_space_sel_n(program_space_sel_n),
    .io_space_sel_n(io_space_sel_n), .memory_strobe_n(memory_strobe_n), .io_strobe_n(io_strobe_n),
    .read_not_write(read_not_write), .ctrl_oe(ctrl_oe), .status_oe(status_oe), .bus_grant_n(bus_grant_n));

// ==== sim/xmbi_mem_partner.sv ====
// Behavioural external memory and I/O device with a programmable ready delay.
`timescale 1ns/1ps
`include "xmbi_defs.svh"
module xmbi_mem_partner (
    input  wire logic                    clk,
    input  wire logic [`XMBI_ADDR_W-1:0] addr_o,
    input  wire logic                    memory_strobe_n,
    input  wire logic                    io_strobe_n,
    input  wire logic                    read_not_write,
    input  wire logic                    ctrl_oe,
    input  wire logic [7:0]              stall,
    output logic                         ready,
    output logic [`XMBI_DATA_W-1:0]      data_i
);
    logic [7:0]              cnt_reg = 8'h00;
    logic [`XMBI_DATA_W-1:0] last_reg = 16'h0000;
    wire active = ctrl_oe && (!memory_strobe_n || !io_strobe_n);
    // Ready stays low outside accesses so a stale high never ends a stretched cycle.
    assign ready = active && (cnt_reg >= stall);
    // A released bus toggles so a stale value is never mistaken for read data.
    assign data_i = (active && read_not_write) ? (addr_o[15:0] ^ 16'h5A5A) : ~last_reg;
    always_ff @(posedge clk) begin
        last_reg <= data_i;
        cnt_reg <= active ? cnt_reg + 8'h01 : 8'h00;
    end
endmodule // xmbi_mem_partner

// ==== sim/testbench.sv ====
// Self-checking testbench of the external memory bus interface.
`timescale 1ns/1ps
`include "xmbi_defs.svh"
module testbench;
    import xmbi_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, chip_reset_n = 1'b0, rom_map_select = 1'b0, tie_wd = 1'b0;
    logic        ovr_valid = 1'b0, ovr_value = 1'b0, output_disable_n = 1'b1, hold_req_n = 1'b1;
    logic [2:0]  ws_p = 3'h0, ws_d = 3'h0, ws_i = 3'h0;
    logic        req_valid = 1'b0, req_write = 1'b0, req_fetch = 1'b0;
    xmbi_space_t req_space = XMBI_SPACE_DATA;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [7:0]  stall = 8'h00;
    wire         req_ready, rsp_valid, rsp_internal, rom_mapped, addr_oe, data_oe, ready, ds_n, ps_n, is_n;
    wire         ms_n, ios_n, rnw, ctrl_oe, bus_grant_n, wait_done_n, fetch_n, status_oe;
    wire  [15:0] rsp_rdata, data_o, data_i;
    wire  [19:0] reset_fetch_addr, addr_o;
    int          miscompares = 0, check_count = 0, cycles = 0, lat, wd_low, l0, l1;
    logic [2:0]  seen_sel;
    logic        seen_ms, seen_ios, seen_wr, seen_fetch, got_int;
    logic [15:0] seen_wd, got_data;

    always #2.5 clk = ~clk;

    xmbi_bus u_xmbi_bus (.clk(clk), .reset_n(reset_n), .chip_reset_n(chip_reset_n),
        .rom_map_select(rom_map_select), .mode_override_valid(ovr_valid), .mode_override_value(ovr_value),
        .output_disable_n(output_disable_n), .ready(tie_wd ? wait_done_n : ready), .hold_req_n(hold_req_n),
        .prog_wait_states(ws_p), .data_wait_states(ws_d), .io_wait_states(ws_i), .req_valid(req_valid),
        .req_ready(req_ready), .req_space(req_space), .req_write(req_write), .req_fetch(req_fetch),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_internal(rsp_internal), .reset_fetch_addr(reset_fetch_addr), .rom_mapped(rom_mapped),
        .addr_o(addr_o), .addr_oe(addr_oe), .data_o(data_o), .data_oe(data_oe), .data_i(data_i),
        .data_space_sel_n(ds_n), .program_space_sel_n(ps_n), .io_space_sel_n(is_n),
        .memory_strobe_n(ms_n), .io_strobe_n(ios_n), .read_not_write(rnw), .ctrl_oe(ctrl_oe),
        .bus_grant_n(bus_grant_n), .wait_done_n(wait_done_n), .fetch_cycle_n(fetch_n), .status_oe(status_oe));

    xmbi_mem_partner u_xmbi_mem_partner (.clk(clk), .addr_o(addr_o), .memory_strobe_n(ms_n),
        .io_strobe_n(ios_n), .read_not_write(rnw), .ctrl_oe(ctrl_oe), .stall(stall), .ready(ready),
        .data_i(data_i));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic access(input xmbi_space_t sp, input logic wr, input logic fe, input logic [19:0] a,
                          input logic [15:0] wd);
        int n = 0;
        {seen_sel, seen_ms, seen_ios, seen_wr, seen_fetch, wd_low, lat} = '0;
        req_valid <= 1'b1;
        req_space <= sp;
        req_write <= wr;
        req_fetch <= fe;
        req_addr <= a;
        req_wdata <= wd;
        do @(posedge clk); while (req_ready !== 1'b1 && ++n < 100);
        req_valid <= 1'b0;
        while (lat < 200) begin
            @(posedge clk);
            lat++;
            seen_sel |= {~is_n, ~ps_n, ~ds_n};
            seen_ms |= ~ms_n;
            seen_ios |= ~ios_n;
            seen_fetch |= ~fetch_n;
            wd_low += (wait_done_n === 1'b0);
            if (rnw === 1'b0) begin
                seen_wr = 1'b1;
                seen_wd = data_o;
            end
            if (rsp_valid === 1'b1) begin
                got_data = rsp_rdata;
                got_int = rsp_internal;
                break;
            end
        end
        @(posedge clk);
    endtask

    task automatic chip_reset(input logic sel);
        chip_reset_n <= 1'b0;
        rom_map_select <= sel;
        wait_cycles(6);
        check_val(bus_grant_n, 1'b1);
        chip_reset_n <= 1'b1;
        wait_cycles(8);
    endtask

    task automatic t_rom_map;
        check_val(reset_fetch_addr, 20'h0FF80);
        check_val(rom_mapped, 1'b1);
        rom_map_select <= 1'b1;
        wait_cycles(8);
        check_val(rom_mapped, 1'b1);
        access(XMBI_SPACE_PROG, 1'b0, 1'b1, 20'h0FF80, 16'h0000);
        check_val({got_int, seen_sel}, 4'h8);
        ovr_valid <= 1'b1;
        ovr_value <= 1'b1;
        wait_cycles(4);
        check_val(rom_mapped, 1'b0);
        access(XMBI_SPACE_PROG, 1'b0, 1'b1, 20'h0FF80, 16'h0000);
        check_val({got_int, seen_sel, seen_ms, seen_fetch}, 6'h0B);
        check_val(got_data, 16'hFF80 ^ 16'h5A5A);
        ovr_valid <= 1'b0;
        chip_reset(1'b1);
        check_val(rom_mapped, 1'b0);
    endtask

    task automatic t_spaces;
        access(XMBI_SPACE_DATA, 1'b0, 1'b0, 20'hA1234, 16'h0000);
        check_val({seen_sel, seen_ms, seen_ios, seen_wr, seen_fetch}, 7'h18);
        check_val(got_data, 16'h1234 ^ 16'h5A5A);
        access(XMBI_SPACE_IO, 1'b0, 1'b0, 20'h00042, 16'h0000);
        check_val({seen_sel, seen_ms, seen_ios, seen_wr}, 6'h22);
        access(XMBI_SPACE_DATA, 1'b1, 1'b0, 20'h00777, 16'hC3A5);
        check_val({seen_wr, seen_wd}, {1'b1, 16'hC3A5});
    endtask

    task automatic t_waits;
        stall <= 8'h09;
        access(XMBI_SPACE_DATA, 1'b0, 1'b0, 20'h00010, 16'h0000);
        l0 = lat;
        ws_d <= 3'h1;
        access(XMBI_SPACE_DATA, 1'b0, 1'b0, 20'h00011, 16'h0000);
        check_val(lat - l0, 1);
        check_val(wd_low, 0);
        stall <= 8'h00;
        ws_d <= 3'h3;
        access(XMBI_SPACE_DATA, 1'b0, 1'b0, 20'h00012, 16'h0000);
        l1 = lat;
        check_val(wd_low, 2);
        check_val(l1 >= l0 + 3, 1'b1);
        stall <= 8'h0C;
        access(XMBI_SPACE_DATA, 1'b0, 1'b0, 20'h00013, 16'h0000);
        check_val(lat > l1 + 5, 1'b1);
        check_val(got_data, 16'h0013 ^ 16'h5A5A);
        tie_wd <= 1'b1;
        access(XMBI_SPACE_DATA, 1'b0, 1'b0, 20'h00014, 16'h0000);
        check_val(got_data, 16'h0014 ^ 16'h5A5A);
        ws_d <= 3'h0;
        stall <= 8'h00;
    endtask

    task automatic t_hold;
        int n = 0;
        hold_req_n <= 1'b0;
        do @(posedge clk); while (bus_grant_n !== 1'b0 && ++n < 50);
        check_val({bus_grant_n, ctrl_oe, addr_oe, data_oe, req_ready}, 5'h00);
        hold_req_n <= 1'b1;
        wait_cycles(10);
        check_val(bus_grant_n, 1'b1);
    endtask

    task automatic t_off;
        output_disable_n <= 1'b0;
        wait_cycles(10);
        check_val({ctrl_oe, status_oe, addr_oe, data_oe}, 4'h0);
        output_disable_n <= 1'b1;
        wait_cycles(10);
        check_val({ctrl_oe, status_oe}, 2'h3);
    endtask

    initial begin
        wait_cycles(3);
        reset_n <= 1'b1;
        wait_cycles(3);
        chip_reset(1'b0);
        t_rom_map();
        t_spaces();
        t_waits();
        t_hold();
        t_off();
        tally_and_finish();
    end
endmodule // testbench
